/* File: core/gpio_port_map.vh */
// Register map, pin masks and reset values of the parallel I/O block
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// Port count and pins of all ports flattened, port p at bits 8p+7..8p
`define GP_PORTS        7
`define GP_BITS         56
`define GP_PIN_COUNT    54

// Zero page: data at 2p, direction at 2p+1
`define GP_ZP_BASE      8'h00
`define GP_ZP_DATA      1'b0
`define GP_ZP_DIR       1'b1

// High page: pullup at 40h+4p, slew at +1, drive at +2
`define GP_HP_BASE      8'h40
`define GP_HP_PULL      2'h0
`define GP_HP_SLEW      2'h1
`define GP_HP_DRIVE     2'h2

// Implemented pins, port G down to port A
`define GP_IMPL_MASK    56'h7F_FF_FF_FF_7F_FF_FF

// Pins with a digital shared function
`define GP_SHARE_MASK   56'h7F_3F_FF_FF_2F_00_00

// Pins with an analog converter input
`define GP_ANALOG_MASK  56'h00_00_00_FF_00_FF_00

// Reset values
`define GP_RST_DATA     56'h00_00_00_00_00_00_00
`define GP_RST_DIR      56'h00_00_00_00_00_00_00
`define GP_RST_PULL     56'h00_00_00_00_00_00_00
`define GP_RST_SLEW     `GP_IMPL_MASK
`define GP_RST_DRIVE    56'h00_00_00_00_00_00_00

`endif

/* File: core/gpio_port_pin_sharing.v */
// Seven-port parallel I/O with peripheral pin sharing
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module gpio_port_pin_sharing #(
   parameter NBITS = `GP_BITS
) (
   input  wire             clk,          // System clock, 100 MHz
   input  wire             reset_n,      // Async reset, active low
   input  wire [7:0]       reg_addr,     // Register address
   input  wire [7:0]       reg_wdata,    // Register write data
   input  wire             reg_wr,       // Write strobe
   input  wire             reg_rd,       // Read strobe
   output reg  [7:0]       reg_rdata,    // Read data, cycle after strobe
   input  wire [NBITS-1:0] pin_in,       // Pin levels from pads
   output reg  [NBITS-1:0] pin_out,      // Pin output values
   output reg  [NBITS-1:0] pin_oe,       // Pin output enables
   output reg  [NBITS-1:0] pin_pullup,   // Pullup enables
   output reg  [NBITS-1:0] pin_slew,     // Slew limit enables
   output reg  [NBITS-1:0] pin_drive,    // High drive selects
   output reg  [NBITS-1:0] pin_level,    // Synced levels to peripherals
   input  wire [NBITS-1:0] periph_en,    // Digital peripheral claims pin
   input  wire [NBITS-1:0] periph_oe,    // Peripheral drives pin
   input  wire [NBITS-1:0] periph_out,   // Peripheral output value
   input  wire [NBITS-1:0] analog_en     // Analog converter claims pin
);

   localparam [NBITS-1:0] IMPL   = `GP_IMPL_MASK;
   localparam [NBITS-1:0] SHARE  = `GP_SHARE_MASK;
   localparam [NBITS-1:0] ANALOG = `GP_ANALOG_MASK;

   // Register storage
   reg  [NBITS-1:0] port_data_register_r;
   reg  [NBITS-1:0] pin_direction_bit_r;
   reg  [NBITS-1:0] pin_pullup_enable_bit_r;
   reg  [NBITS-1:0] pin_slew_limit_bit_r;
   reg  [NBITS-1:0] pin_drive_strength_bit_r;

   // Claim registers, cleared by reset
   reg  [NBITS-1:0] dig_claim_r;
   reg  [NBITS-1:0] dig_oe_r;
   reg  [NBITS-1:0] dig_out_r;
   reg  [NBITS-1:0] ana_claim_r;

   // Pin input synchroniser
   reg  [NBITS-1:0] sync1_r;
   reg  [NBITS-1:0] sync2_r;
   reg  [NBITS-1:0] sync3_r;
   reg  [NBITS-1:0] pin_sync_r;
   reg  [NBITS-1:0] pin_sync_nxt;

   // Decode
   wire [2:0] zp_port = reg_addr[3:1];
   wire [2:0] hp_port = reg_addr[4:2];
   wire [1:0] hp_kind = reg_addr[1:0];
   wire       zp_hit  = (reg_addr[7:4] == `GP_ZP_BASE >> 4)
                        && (zp_port < `GP_PORTS);
   wire       hp_hit  = (reg_addr[7:5] == `GP_HP_BASE >> 5)
                        && (hp_port < `GP_PORTS)
                        && (hp_kind != 2'h3);

   // Effective pin ownership
   reg  [NBITS-1:0] ana_own;
   reg  [NBITS-1:0] dig_own;
   reg  [NBITS-1:0] oe_nxt;
   reg  [NBITS-1:0] out_nxt;
   reg  [NBITS-1:0] pull_nxt;
   reg  [NBITS-1:0] rdbits;
   reg  [7:0]       rdata_nxt;

   always @*
   begin
      ana_own  = ana_claim_r & ANALOG & IMPL;
      dig_own  = dig_claim_r & SHARE & IMPL & ~ana_own;
      oe_nxt   = ((dig_own & dig_oe_r)
                 | (~dig_own & pin_direction_bit_r))
                 & ~ana_own & IMPL;
      out_nxt  = ((dig_own & dig_oe_r & dig_out_r)
                 | (~(dig_own & dig_oe_r) & port_data_register_r))
                 & oe_nxt;
      pull_nxt = pin_pullup_enable_bit_r & ~oe_nxt & ~ana_own & IMPL;
      rdbits   = ((pin_direction_bit_r & port_data_register_r)
                 | (~pin_direction_bit_r & pin_sync_r))
                 & ~ana_own & IMPL;
   end

   // Filtered pin level: change taken when stages two and three agree
   always @*
   begin
      pin_sync_nxt = (sync2_r & ~(sync2_r ^ sync3_r))
                     | (pin_sync_r & (sync2_r ^ sync3_r));
   end

   // Read mux
   always @*
   begin
      rdata_nxt = 8'h00;
      if (zp_hit)
      begin
         if (reg_addr[0] == `GP_ZP_DATA)
            rdata_nxt = rdbits[zp_port*8 +: 8];
         else
            rdata_nxt = pin_direction_bit_r[zp_port*8 +: 8]
                        & IMPL[zp_port*8 +: 8];
      end
      else if (hp_hit)
      begin
         case (hp_kind)
            `GP_HP_PULL:  rdata_nxt = pin_pullup_enable_bit_r[hp_port*8 +: 8];
            `GP_HP_SLEW:  rdata_nxt = pin_slew_limit_bit_r[hp_port*8 +: 8];
            `GP_HP_DRIVE: rdata_nxt =
                             pin_drive_strength_bit_r[hp_port*8 +: 8];
            default:      rdata_nxt = 8'h00;
         endcase
      end
   end

   // Register writes; unimplemented bits stay zero
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         port_data_register_r     <= `GP_RST_DATA;
         pin_direction_bit_r      <= `GP_RST_DIR;
         pin_pullup_enable_bit_r  <= `GP_RST_PULL;
         pin_slew_limit_bit_r     <= `GP_RST_SLEW;
         pin_drive_strength_bit_r <= `GP_RST_DRIVE;
      end
      else if (reg_wr && zp_hit)
      begin
         if (reg_addr[0] == `GP_ZP_DATA)
            port_data_register_r[zp_port*8 +: 8] <=
               reg_wdata & IMPL[zp_port*8 +: 8];
         else
            pin_direction_bit_r[zp_port*8 +: 8] <=
               reg_wdata & IMPL[zp_port*8 +: 8];
      end
      else if (reg_wr && hp_hit)
      begin
         case (hp_kind)
            `GP_HP_PULL:  pin_pullup_enable_bit_r[hp_port*8 +: 8] <=
                             reg_wdata & IMPL[hp_port*8 +: 8];
            `GP_HP_SLEW:  pin_slew_limit_bit_r[hp_port*8 +: 8] <=
                             reg_wdata & IMPL[hp_port*8 +: 8];
            `GP_HP_DRIVE: pin_drive_strength_bit_r[hp_port*8 +: 8] <=
                             reg_wdata & IMPL[hp_port*8 +: 8];
            default:      pin_drive_strength_bit_r <=
                             pin_drive_strength_bit_r;
         endcase
      end
   end

   // Digital claims; reset leaves pins to parallel I/O
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         dig_claim_r <= {NBITS{1'b0}};
      else
         dig_claim_r <= periph_en & SHARE;
   end

   // Peripheral drive request
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         dig_oe_r <= {NBITS{1'b0}};
      else
         dig_oe_r <= periph_oe;
   end

   // Peripheral output value
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         dig_out_r <= {NBITS{1'b0}};
      else
         dig_out_r <= periph_out;
   end

   // Analog claims
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ana_claim_r <= {NBITS{1'b0}};
      else
         ana_claim_r <= analog_en & ANALOG;
   end

   // Sync stage one, straight from the pads
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         sync1_r <= {NBITS{1'b0}};
      else
         sync1_r <= pin_in;
   end

   // Sync stage two
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         sync2_r <= {NBITS{1'b0}};
      else
         sync2_r <= sync1_r;
   end

   // Sync stage three
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         sync3_r <= {NBITS{1'b0}};
      else
         sync3_r <= sync2_r;
   end

   // Filtered level
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pin_sync_r <= {NBITS{1'b0}};
      else
         pin_sync_r <= pin_sync_nxt & IMPL;
   end

   // Read data, one cycle only
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
   end

   // Pin output values
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pin_out <= {NBITS{1'b0}};
      else
         pin_out <= out_nxt;
   end

   // Pin output enables
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pin_oe <= {NBITS{1'b0}};
      else
         pin_oe <= oe_nxt;
   end

   // Pullup enables
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pin_pullup <= {NBITS{1'b0}};
      else
         pin_pullup <= pull_nxt;
   end

   // Slew limit enables
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pin_slew <= `GP_RST_SLEW;
      else
         pin_slew <= pin_slew_limit_bit_r & ~ana_own;
   end

   // High drive selects
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pin_drive <= {NBITS{1'b0}};
      else
         pin_drive <= pin_drive_strength_bit_r & ~ana_own;
   end

   // Levels handed to the peripherals
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pin_level <= {NBITS{1'b0}};
      else
         pin_level <= pin_sync_r & ~ana_own;
   end

endmodule // gpio_port_pin_sharing

/* File: testbench/gpio_port_pin_sharing_chk.sv */
// Assertion checker for the parallel I/O block
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module gpio_port_pin_sharing_chk #(
   parameter NBITS = 56
) (
   input wire logic             clk,
   input wire logic             reset_n,
   input wire logic [7:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [7:0]       reg_rdata,
   input wire logic [NBITS-1:0] pin_out,
   input wire logic [NBITS-1:0] pin_oe,
   input wire logic [NBITS-1:0] pin_pullup,
   input wire logic [NBITS-1:0] pin_slew,
   input wire logic [NBITS-1:0] pin_drive,
   input wire logic [NBITS-1:0] periph_en,
   input wire logic [NBITS-1:0] periph_oe,
   input wire logic [NBITS-1:0] periph_out,
   input wire logic [NBITS-1:0] analog_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   unmapped_read_a: assert property (reg_rd && reg_addr == 8'h20 |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");
   reset_state_a: assert property ($rose(reset_n) |->
      pin_slew == `GP_RST_SLEW && pin_oe == 0 && pin_drive == 0 &&
      pin_pullup == 0) else $error("pin control not at reset state");
   analog_oe_a: assert property (((pin_oe | pin_pullup) &
      $past(analog_en) & $past(analog_en, 2) & `GP_ANALOG_MASK) == 0)
      else $error("analog pin still driven");
   analog_ctrl_a: assert property (((pin_slew | pin_drive) &
      $past(analog_en) & $past(analog_en, 2) & `GP_ANALOG_MASK) == 0)
      else $error("analog pin keeps digital control");
   periph_dir_a: assert property (((pin_oe ^ $past(periph_oe, 2)) &
      $past(periph_en, 2) & $past(periph_en) & ~$past(analog_en, 2) &
      ~$past(analog_en) & `GP_SHARE_MASK) == 0)
      else $error("direction not from peripheral");
   periph_val_a: assert property (((pin_out ^ $past(periph_out, 2)) &
      $past(periph_en, 2) & $past(periph_en) & $past(periph_oe, 2) &
      $past(periph_oe) & ~$past(analog_en, 2) & ~$past(analog_en) &
      `GP_SHARE_MASK) == 0) else $error("output value not from peripheral");
   dir_write_a: assert property (reg_wr && reg_addr == 8'h01 ##1
      !(reg_wr && reg_addr == 8'h01) [*2] |->
      pin_oe[7:0] == $past(reg_wdata, 2)) else $error("direction write lost");
endmodule // gpio_port_pin_sharing_chk
bind gpio_port_pin_sharing gpio_port_pin_sharing_chk #(.NBITS(NBITS)) chk (
   .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
   .pin_slew(pin_slew), .pin_drive(pin_drive), .periph_en(periph_en),
   .periph_oe(periph_oe), .periph_out(periph_out), .analog_en(analog_en));

/* File: testbench/pin_board_model.sv */
// Board side of the pads: driven pins loop back, others follow the board
`timescale 1ns/1ps
module pin_board_model (
   input  wire logic [55:0] pin_out,    // Driven values
   input  wire logic [55:0] pin_oe,     // Drive enables
   input  wire logic [55:0] ext_level,  // Board source levels
   output wire logic [55:0] pin_in      // Pad levels
);
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_board_model

/* File: testbench/gpio_port_pin_sharing_tb.sv */
// Self-checking bench for the parallel I/O block
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module gpio_port_pin_sharing_tb;
   logic        clk, reset_n, reg_wr, reg_rd;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [55:0] pin_in, pin_out, pin_oe, pin_pullup, pin_slew, pin_drive;
   logic [55:0] pin_level, periph_en, periph_oe, periph_out, analog_en;
   logic [55:0] ext_level;
   logic [55:0] impl = `GP_IMPL_MASK;
   int          n_fail = 0;
   int          tests_run = 0;
   gpio_port_pin_sharing DUT (.clk(clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .pin_slew(pin_slew), .pin_drive(pin_drive), .pin_level(pin_level),
      .periph_en(periph_en), .periph_oe(periph_oe),
      .periph_out(periph_out), .analog_en(analog_en));
   pin_board_model pb (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext_level), .pin_in(pin_in));
   task automatic check(input logic [55:0] seen, input logic [55:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      #1 check(reg_rdata, e);
   endtask
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic reset_scan;
      check(pin_slew, `GP_RST_SLEW);
      check(pin_oe | pin_pullup | pin_drive, 0);
      for (int p = 0; p < 7; p++)
      begin
         rdc(8'(2 * p + 1), 8'h00);
         rdc(8'(8'h40 + 4 * p), 8'h00);
         rdc(8'(8'h41 + 4 * p), impl[8 * p +: 8]);
         rdc(8'(8'h42 + 4 * p), 8'h00);
      end
   endtask
   task automatic gpio_a;
      wr(8'h00, 8'h55);
      wr(8'h01, 8'hFF);
      @(posedge clk) ext_level[7:0] <= 8'hAA;
      settle;
      check(pin_oe[7:0], 8'hFF);
      rdc(8'h00, 8'h55);
      wr(8'h01, 8'h00);
      settle;
      check(pin_level[7:0], 8'hAA);
      rdc(8'h00, 8'hAA);
   endtask
   task automatic port_f;
      wr(8'h0A, 8'hC3);
      wr(8'h0B, 8'hC0);
      @(posedge clk) {periph_en[47:40], periph_oe[47:40]} <= 16'hFF3E;
      periph_out[47:40] <= 8'h2A;
      settle;
      check(pin_oe[47:40], 8'hFE);
      check(pin_out[47:40], 8'hEA);
      rdc(8'h0A, 8'hEA);
   endtask
   task automatic analog_d;
      wr(8'h06, 8'hFF);
      wr(8'h07, 8'hFF);
      @(posedge clk) {periph_en[31:24], periph_oe[31:24],
         analog_en[31:24]} <= 24'hFFFFF0;
      settle;
      check(pin_oe[31:24], 8'h0F);
      check(pin_slew[31:24], 8'h0F);
      rdc(8'h06, 8'h0F);
      wr(8'h20, 8'hFF);
      rdc(8'h20, 8'h00);
   endtask
   task automatic complete_run;
      if (n_fail == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #200us;
      n_fail++;
      complete_run;
   end
   initial
   begin
      {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
      {periph_en, periph_oe, periph_out} = {168{1'b1}};
      {analog_en, ext_level} = 0;
      repeat (14) @(posedge clk);
      #1 check(pin_oe, 0);
      @(posedge clk) {periph_en, periph_oe, periph_out} <= 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      reset_scan;
      gpio_a;
      port_f;
      analog_d;
      complete_run;
   end
endmodule // gpio_port_pin_sharing_tb
